// ===== logic/ctrc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctrc_params.svh"
module ctrc_host
  import ctrc_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Request side
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire ctrc_req_s              req,
  input  wire logic                   clear_req,
  output logic                        clear_busy,
  // Answer side
  output logic                        rsp_valid,
  output ctrc_rsp_s                   rsp,
  // Device pins
  output logic [`CTRC_IDX_W-1:0]      tag_index,
  output logic [`CTRC_TAG_W-1:0]      tag_value_o,
  output logic                        tag_value_oe,
  input  wire logic [`CTRC_TAG_W-1:0] tag_value_i,
  output logic                        write_n,
  output logic                        out_en_n,
  output logic                        bulk_zero_n,
  input  wire logic                   hit
);
  ctrc_state_e            state_q, state_d;
  ctrc_op_e               op_q;
  logic [`CTRC_IDX_W-1:0] index_q;
  logic [`CTRC_TAG_W-1:0] tag_q;
  logic                   write_n_q, out_en_n_q, zero_n_q, oe_q;
  logic                   rsp_valid_q;
  ctrc_rsp_s              rsp_q;
  logic                   tmr_load, tmr_done;
  logic [`CTRC_CNT_W-1:0] tmr_count;

  function automatic logic [`CTRC_CNT_W-1:0] cyc(input int n);
    cyc = (n > 1) ? `CTRC_CNT_W'(n - 1) : '0;
  endfunction

  wire take_clr = (state_q == CTRC_IDLE) && clear_req;
  wire take_req = (state_q == CTRC_IDLE) && !clear_req && req_valid;
  wire is_wr    = (op_q == CTRC_OP_WRITE);
  wire is_rd    = (op_q == CTRC_OP_READ);
  wire finish   = (state_q == CTRC_PULSE) && tmr_done;

  assign req_ready    = (state_q == CTRC_IDLE) && !clear_req;
  assign clear_busy   = (state_q == CTRC_CLR) || (state_q == CTRC_DONE);
  assign tag_index    = index_q;
  assign tag_value_o  = tag_q;
  assign tag_value_oe = oe_q;
  assign write_n      = write_n_q;
  assign out_en_n     = out_en_n_q;
  assign bulk_zero_n  = zero_n_q;
  assign rsp_valid    = rsp_valid_q;
  assign rsp          = rsp_q;

  // Timer loads: access time for cycles, pulse width for clear, recovery after
  assign tmr_load  = take_req || take_clr || finish ||
                     ((state_q == CTRC_CLR) && tmr_done);
  assign tmr_count = take_clr ? cyc(`CTRC_CLRPW_CYC) :
                     (take_req ? cyc(`CTRC_ACC_CYC) : cyc(`CTRC_REC_CYC));

  ctrc_timer u_timer (
    .clk     (clk),
    .rst     (rst),
    .load    (tmr_load),
    .count   (tmr_count),
    .expired (tmr_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      CTRC_IDLE:  begin
        if (take_clr) begin
          state_d = CTRC_CLR;
        end else if (take_req) begin
          state_d = CTRC_PULSE;
        end
      end
      CTRC_PULSE: if (tmr_done) state_d = CTRC_HOLD;
      CTRC_HOLD:  if (tmr_done) state_d = CTRC_IDLE;
      CTRC_CLR:   if (tmr_done) state_d = CTRC_DONE;
      CTRC_DONE:  if (tmr_done) state_d = CTRC_IDLE;
      default:    state_d = CTRC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= CTRC_IDLE;
      op_q    <= CTRC_OP_MATCH;
      index_q <= '0;
      tag_q   <= '0;
    end else begin
      state_q <= state_d;
      if (take_req) begin
        op_q    <= req.op;
        index_q <= req.index;
        tag_q   <= req.tag;
      end
    end
  end

  // Strobes; bus held one cycle past the write pulse so data outlasts the latch edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_n_q  <= 1'b1;
      out_en_n_q <= 1'b1;
      zero_n_q   <= 1'b1;
      oe_q       <= 1'b0;
    end else begin
      zero_n_q   <= !(state_d == CTRC_CLR);
      write_n_q  <= !((state_d == CTRC_PULSE) && (take_req ? req.op == CTRC_OP_WRITE : is_wr));
      out_en_n_q <= !((state_d == CTRC_PULSE) && (take_req ? req.op == CTRC_OP_READ : is_rd));
      // Bus released for read and clear so the device may drive it
      oe_q       <= ((state_d == CTRC_PULSE) || (state_d == CTRC_HOLD)) &&
                    !(take_req ? req.op == CTRC_OP_READ : is_rd);
    end
  end

  // Answer sampled at end of one access cycle; hit only kept for matches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end else begin
      rsp_valid_q <= finish;
      if (finish) begin
        rsp_q.hit <= (op_q == CTRC_OP_MATCH) ? hit : 1'b0;
        rsp_q.tag <= is_rd ? tag_value_i : tag_q;
      end
    end
  end

  // Hit pin never sampled while clearing NAND merge left outside

  property p_clr_strobes;
    @(posedge clk) disable iff (rst)
      !bulk_zero_n |-> (write_n && out_en_n && !rsp_valid);
  endproperty
  a_clr_strobes: assert property (p_clr_strobes) else $error("strobes during clear");

  property p_clr_width;
    @(posedge clk) disable iff (rst)
      $fell(bulk_zero_n) |-> !bulk_zero_n [*5];
  endproperty
  a_clr_width: assert property (p_clr_width) else $error("clear pulse too short");

  property p_match_pins;
    @(posedge clk) disable iff (rst)
      (state_q == CTRC_PULSE && op_q == CTRC_OP_MATCH) |->
        (write_n && out_en_n && bulk_zero_n && tag_value_oe);
  endproperty
  a_match_pins: assert property (p_match_pins) else $error("match strobes wrong");

  property p_read_float;
    @(posedge clk) disable iff (rst)
      !out_en_n |-> !tag_value_oe;
  endproperty
  a_read_float: assert property (p_read_float) else $error("bus contention on read");

  property p_write_data;
    @(posedge clk) disable iff (rst)
      !write_n |-> (tag_value_oe && bulk_zero_n && ($fell(write_n) || $stable(tag_value_o)));
  endproperty
  a_write_data: assert property (p_write_data) else $error("write data unstable");

  property p_rsp_time;
    @(posedge clk) disable iff (rst)
      take_req |-> ##[5:6] rsp_valid;
  endproperty
  a_rsp_time: assert property (p_rsp_time) else $error("answer late");

  property p_hit_only_match;
    @(posedge clk) disable iff (rst)
      (rsp_valid && $past(op_q) != CTRC_OP_MATCH) |-> !rsp.hit;
  endproperty
  a_hit_only_match: assert property (p_hit_only_match) else $error("hit kept outside match");

  property p_read_data;
    @(posedge clk) disable iff (rst)
      (finish && is_rd) |=> (rsp.tag == $past(tag_value_i));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not captured");

  property p_pins_stand;
    @(posedge clk) disable iff (rst)
      (state_q == CTRC_PULSE && $past(state_q) == CTRC_PULSE) |->
        ($stable(tag_index) && $stable(tag_value_o));
  endproperty
  a_pins_stand: assert property (p_pins_stand) else $error("index or compare value moved");

  property p_clr_recover;
    @(posedge clk) disable iff (rst)
      $rose(bulk_zero_n) |=> (write_n && out_en_n);
  endproperty
  a_clr_recover: assert property (p_clr_recover) else $error("strobe right after clear");

  c_match: cover property (@(posedge clk) disable iff (rst) rsp_valid && rsp.hit);
  c_write: cover property (@(posedge clk) disable iff (rst) $fell(write_n));
  c_read:  cover property (@(posedge clk) disable iff (rst) $fell(out_en_n));
  c_clear: cover property (@(posedge clk) disable iff (rst) $rose(bulk_zero_n));
endmodule // ctrc_host
`default_nettype wire

// ===== logic/ctrc_params.svh
`ifndef CTRC_PARAMS_SVH
`define CTRC_PARAMS_SVH
`define CTRC_IDX_W        12
`define CTRC_TAG_W        4
`define CTRC_CLK_NS       5
`define CTRC_ACC_NS       25
`define CTRC_ACC_CYC      ((`CTRC_ACC_NS + `CTRC_CLK_NS - 1) / `CTRC_CLK_NS)
`define CTRC_CLRPW_NS     25
`define CTRC_CLRPW_CYC    ((`CTRC_CLRPW_NS + `CTRC_CLK_NS - 1) / `CTRC_CLK_NS)
`define CTRC_REC_NS       5
`define CTRC_REC_CYC      ((`CTRC_REC_NS + `CTRC_CLK_NS - 1) / `CTRC_CLK_NS)
`define CTRC_CNT_W        4
`endif

// ===== logic/ctrc_pkg.sv
`include "ctrc_params.svh"
package ctrc_pkg;
  typedef enum logic [2:0] {
    CTRC_OP_MATCH = 3'h1,
    CTRC_OP_WRITE = 3'h2,
    CTRC_OP_READ  = 3'h4
  } ctrc_op_e;
  typedef enum logic [5:0] {
    CTRC_IDLE  = 6'h01,
    CTRC_SETUP = 6'h02,
    CTRC_PULSE = 6'h04,
    CTRC_HOLD  = 6'h08,
    CTRC_CLR   = 6'h10,
    CTRC_DONE  = 6'h20
  } ctrc_state_e;
  typedef struct packed {
    ctrc_op_e                  op;
    logic [`CTRC_IDX_W-1:0]    index;
    logic [`CTRC_TAG_W-1:0]    tag;
  } ctrc_req_s;
  typedef struct packed {
    logic                      hit;
    logic [`CTRC_TAG_W-1:0]    tag;
  } ctrc_rsp_s;
endpackage

// ===== logic/ctrc_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctrc_params.svh"
module ctrc_timer
  import ctrc_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Control
  input  wire logic                   load,
  input  wire logic [`CTRC_CNT_W-1:0] count,
  output logic                        expired
);
  logic [`CTRC_CNT_W-1:0] cnt_q;
  assign expired = (cnt_q == '0);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (!expired) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // ctrc_timer
`default_nettype wire

// ===== sim/ctrc_tag_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctrc_params.svh"
module ctrc_tag_model
(
  // Device pins
  input  wire logic [`CTRC_IDX_W-1:0] tag_index,
  input  wire logic [`CTRC_TAG_W-1:0] bus,
  input  wire logic                   write_n,
  input  wire logic                   out_en_n,
  input  wire logic                   bulk_zero_n,
  output logic [`CTRC_TAG_W-1:0]      dev_o,
  output logic                        dev_oe,
  output logic                        hit
);
  logic [`CTRC_TAG_W-1:0] mem [0:4095];
  wire                    same = (mem[tag_index] == bus);
  // Clear leaves hit enabled but garbled
  assign hit = bulk_zero_n ? same : ~same;
  assign dev_oe = !out_en_n && (write_n || !bulk_zero_n);
  // Nonzero junk during clear so a careless host is caught
  assign dev_o = bulk_zero_n ? mem[tag_index] : 4'hf;
  always @(posedge write_n) begin
    if (bulk_zero_n === 1'b1) mem[tag_index] = bus;
  end
  always @(negedge bulk_zero_n) begin
    for (int i = 0; i < 4096; i++) mem[i] = 4'h0;
  end
endmodule // ctrc_tag_model
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctrc_params.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); num_errors++; end end
module tb
  import ctrc_pkg::*;
;
  logic       clk = 0;
  logic       rst = 1;
  logic       req_valid = 0;
  logic       clear_req = 0;
  ctrc_req_s  req = '0;
  logic       req_ready, clear_busy, rsp_valid, host_oe, dev_oe, hit;
  logic       write_n, out_en_n, bulk_zero_n;
  ctrc_rsp_s  rsp;
  logic [11:0] idx;
  logic [3:0] host_o, dev_o, last_q = 4'h0;
  wire  [3:0] bus = host_oe ? host_o : (dev_oe ? dev_o : ~last_q);
  int         num_errors = 0;
  int         n_compared = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (host_oe || dev_oe) last_q <= bus;
  ctrc_host dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .clear_req(clear_req), .clear_busy(clear_busy), .rsp_valid(rsp_valid),
    .rsp(rsp), .tag_index(idx), .tag_value_o(host_o), .tag_value_oe(host_oe),
    .tag_value_i(bus), .write_n(write_n), .out_en_n(out_en_n),
    .bulk_zero_n(bulk_zero_n), .hit(hit));
  ctrc_tag_model dev (.tag_index(idx), .bus(bus), .write_n(write_n), .out_en_n(out_en_n),
    .bulk_zero_n(bulk_zero_n), .dev_o(dev_o), .dev_oe(dev_oe), .hit(hit));
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_op(input ctrc_op_e op, input logic [11:0] ix, input logic [3:0] tg,
                       input logic eh, input logic [3:0] et);
    int n;
    logic rdy;
    @(posedge clk);
    req <= '{op: op, index: ix, tag: tg};
    req_valid <= 1'b1;
    n = 0;
    do begin #1; rdy = req_ready; @(posedge clk); n++; end while (rdy !== 1'b1 && n < 40);
    req_valid <= 1'b0;
    if (rdy !== 1'b1) begin num_errors++; wrap_up(); end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 3) begin
        `CHK("write_n", (op != CTRC_OP_WRITE), write_n)
        `CHK("out_en_n", (op != CTRC_OP_READ), out_en_n)
        `CHK("oe", (op != CTRC_OP_READ), host_oe)
        `CHK("index", ix, idx)
      end
    end while (rsp_valid !== 1'b1 && n < 20);
    if (n >= 20) begin num_errors++; wrap_up(); end
    `CHK("latency", `CTRC_ACC_CYC, n)
    `CHK("hit", eh, rsp.hit)
    `CHK("tag", et, rsp.tag)
  endtask
  task automatic do_clear();
    int n;
    int lows;
    @(posedge clk);
    clear_req <= 1'b1;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (clear_busy !== 1'b1 && n < 20);
    lows = 0;
    n = 0;
    do begin
      if (bulk_zero_n === 1'b0) lows++;
      `CHK("ready_in_clear", 1'b0, req_ready)
      @(posedge clk);
      clear_req <= 1'b0;
      #1;
      n++;
    end while (clear_busy === 1'b1 && n < 20);
    if (n >= 20) begin num_errors++; wrap_up(); end
    `CHK("clear_low", `CTRC_CLRPW_CYC, lows)
    `CHK("bulk_idle", 1'b1, bulk_zero_n)
  endtask
  task automatic t_write_read();
    do_op(CTRC_OP_WRITE, 12'h000, 4'ha, 1'b0, 4'ha);
    do_op(CTRC_OP_WRITE, 12'hfff, 4'h5, 1'b0, 4'h5);
    do_op(CTRC_OP_READ, 12'h000, 4'h0, 1'b0, 4'ha);
    do_op(CTRC_OP_READ, 12'hfff, 4'h0, 1'b0, 4'h5);
  endtask
  task automatic t_match();
    // Rewrite of the same value makes the pin show a hit that must be ignored
    do_op(CTRC_OP_WRITE, 12'h000, 4'ha, 1'b0, 4'ha);
    // Each single-bit difference must miss
    for (int b = 0; b < 4; b++) begin
      do_op(CTRC_OP_MATCH, 12'h000, 4'ha ^ (4'h1 << b), 1'b0, 4'ha ^ (4'h1 << b));
    end
    do_op(CTRC_OP_MATCH, 12'h000, 4'ha, 1'b1, 4'ha);
  endtask
  task automatic t_clear();
    do_clear();
    do_op(CTRC_OP_READ, 12'hfff, 4'h0, 1'b0, 4'h0);
    do_op(CTRC_OP_MATCH, 12'hfff, 4'h5, 1'b0, 4'h5);
    do_op(CTRC_OP_MATCH, 12'h000, 4'h0, 1'b1, 4'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    do_clear();
    t_write_read();
    t_match();
    t_clear();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
